// ==== mfs_cfg.svh ====
// Purpose: addresses, field positions, reset values and counts of the frame security engine
// Assumes: byte RAM index n sits at AHB byte address 4*n
// Notes: definitions only
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH
`define MFS_MEM_BYTES 352
`define MFS_RAM_TOP 9'h160
`define MFS_TX_BASE 9'h000
`define MFS_RX_BASE 9'h080
`define MFS_KEY_A 9'h100
`define MFS_NONCE_RX 9'h110
`define MFS_SA_BUF 9'h120
`define MFS_KEY_B 9'h130
`define MFS_NONCE_TX 9'h140
`define MFS_REG_CTRL_A 9'h160
`define MFS_REG_CTRL_B 9'h161
`define MFS_REG_STROBE 9'h162
`define MFS_REG_STATUS 9'h163
`define MFS_REG_TX_PUSH 9'h164
`define MFS_REG_RX_POP 9'h165
`define MFS_REG_PREV 9'h166
`define MFS_REG_NONE 9'h1FF
`define MFS_STB_SA 0
`define MFS_STB_TXENC 1
`define MFS_STB_TXON 2
`define MFS_STB_TXCCA 3
`define MFS_STB_RXDEC 4
`define MFS_ST_BUSY 0
`define MFS_ST_TXACT 1
`define MFS_ST_MICOK 2
`define MFS_CTRL_A_RST 9'h000
`define MFS_CTRL_B_RST 14'h0000
`define MFS_AES_LAST 4'hA
`define MFS_MIC_PASS 8'h00
`define MFS_MIC_FAIL 8'hFF
`endif

// ==== mfs_pkg.sv ====
// Purpose: types shared by the frame security engine
// Assumes: nothing
// Notes: field order of the control words is the bit layout, MSB first
package mfs_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_CBC, MODE_CTR, MODE_CCM} mfs_mode_type;
  typedef enum {S_IDLE, S_AESGO, S_AES, S_SAWB, S_START, S_NEXT, S_MAC, S_CBCD,
    S_CTRKS, S_CTR, S_MIC, S_SEND} mfs_state_type;
  typedef struct packed {
    logic prefixSel;
    logic saKey;
    logic rxKey;
    logic txKey;
    logic [2:0] micCode;
    mfs_mode_type mode;
  } mfs_ctrl_a_type;
  typedef struct packed {
    logic [6:0] rxl;
    logic [6:0] txl;
  } mfs_ctrl_b_type;
endpackage

// ==== mfs_engine.sv ====
// Purpose: AES-128 stand-alone and in-line CTR / CBC-MAC / CCM frame security engine
// Assumes: AHB-Lite word transfers only; link clock and link data sampled on clk
// Notes: one AES round per cycle; frames start with their length byte
// Summary of operation
// [R1] Two keys, per-path key selection
// [R2] Keys at RAM 0x100 and 0x130
// [R3] Nonces: receive 0x110, transmit 0x140
// [R4] Nonce: flags, address, counters, block count
// [R5] Block counter copied locally, never written back
// [R6] Host bumps frame counter per packet
// [R7] Stand-alone strobe encrypts buffer 0x120 in place
// [R8] RAM writes return the previous byte
// [R9] Host supplies correct frame length byte
// [R10] Host programs keys, nonce, controls first
// [R11] Modes: off, CBC-MAC, CTR, CCM
// [R12] Encrypt-only strobe processes, never transmits
// [R13] Transmit strobes secure frame, then transmit
// [R14] Receive strobe processes first buffered frame
// [R15] Receive strobe drops data-available pins
// [R16] CTR skips header-length bytes after length
// [R17] Transmit processing stalls for unwritten bytes
// [R18] MIC length code is (M-2)/2
// [R19] Transmit MIC appended into frame
// [R20] Optional authentication length prefix byte
// [R21] Receive MIC check marks last byte
// [R22] CCM header bytes authenticated, not encrypted
// [R23] Strobes ignored while busy; busy flag
// [R24] Security data stored little-endian
`timescale 1ns/1ps
`include "mfs_cfg.svh"
module mfs_engine
  import mfs_pkg::*;
#(
  parameter int BUF_BYTES = 128
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic linkClk,
  input wire logic rxLinkValid,
  input wire logic [7:0] rxLinkData,
  output logic [7:0] txLinkData,
  output logic txLinkActive,
  output logic rxDataAvail,
  output logic rxThresholdPin
);
  if (BUF_BYTES != 128)
  begin : g_chk
    $error("mfs_engine: buffer addressing serves 128 bytes only");
  end

  logic [7:0] mem [0:`MFS_MEM_BYTES-1];
  mfs_ctrl_a_type ctrlA;
  mfs_ctrl_b_type ctrlB;
  mfs_state_type st, retSt;
  logic dValid, dWrite, rdDone;
  logic [8:0] dIdx;
  logic [31:0] rdWord;
  logic [7:0] prevData, txCount, idx, j, doneOff;
  logic [6:0] rxHead, rxTail, fstart, frameOff;
  logic [127:0] aesS, aesK, aesSrc, mac, blk;
  logic [7:0] rcon;
  logic [3:0] rnd;
  logic aesRun, isRx, isCcm, doMac, doCtr, sendAfter, macDone, ctrDone, micDone;
  logic micOk, micPass, txOn;
  logic [8:0] keyBase, nonceBase;
  logic [15:0] ctr;
  logic lkS1, lkS2, lkS3, rvS1, rvS2;
  logic [7:0] rdS1, rdS2;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) r = r ^ a;
      a = xt(a);
    end
    return r;
  endfunction
  // Inverse as x^254 keeps the S-box table-free at the cost of logic depth
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] p, r;
    p = x;
    r = 8'h01;
    for (int i = 1; i < 8; i++)
    begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
  endfunction
  function automatic logic [127:0] aesRound(input logic [127:0] s, input logic [127:0] k,
                                            input logic last);
    logic [127:0] t, m;
    logic [7:0] a0, a1, a2, a3;
    t = '0;
    m = '0;
    for (int n = 0; n < 16; n++)
      t[127-8*n -: 8] = sbox(s[127-8*(4*((n/4+n%4)%4)+n%4) -: 8]);
    for (int c = 0; c < 4; c++)
    begin
      a0 = t[127-32*c -: 8];
      a1 = t[119-32*c -: 8];
      a2 = t[111-32*c -: 8];
      a3 = t[103-32*c -: 8];
      m[127-32*c -: 8] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
      m[119-32*c -: 8] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
      m[111-32*c -: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
      m[103-32*c -: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
    end
    return (last ? t : m) ^ k;
  endfunction
  function automatic logic [127:0] nextKey(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0, w1, w2, w3;
    w3 = k[31:0];
    w0 = k[127:96] ^ {sbox(w3[23:16]) ^ rc, sbox(w3[15:8]), sbox(w3[7:0]), sbox(w3[31:24])};
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = w3 ^ w2;
    return {w0, w1, w2, w3};
  endfunction
  // Lowest RAM address holds the least significant byte
  function automatic logic [127:0] ramBlk(input logic [8:0] b);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
      r[8*i +: 8] = mem[b + 9'(i)]; // [R24]
    return r;
  endfunction
  function automatic logic [127:0] ctrBlk(input logic [8:0] b, input logic [15:0] c);
    logic [127:0] r;
    r = ramBlk(b);
    r[15:0] = c; // [R4] [R5]
    return r;
  endfunction
  function automatic logic [127:0] setByte(input logic [127:0] b, input logic [7:0] n,
                                           input logic [7:0] v);
    b[127-8*n -: 8] = v;
    return b;
  endfunction

  // Bus decode
  wire addrTake = hsel & hready & htrans[1];
  wire wrNow = dValid & dWrite;
  wire rdNow = dValid & ~dWrite & ~rdDone;
  wire hostRamWe = wrNow & (dIdx < `MFS_RAM_TOP);
  wire [4:0] stb = (wrNow && dIdx == `MFS_REG_STROBE) ? hwdata[4:0] : 5'h00;
  wire txPush = wrNow && dIdx == `MFS_REG_TX_PUSH && txCount < 8'h80;
  wire rxPop = rdNow && dIdx == `MFS_REG_RX_POP && rxHead != rxTail;
  wire busy = st != S_IDLE;
  assign hreadyout = ~rdNow;
  assign hresp = 1'b0;

  // Frame geometry of the operation in progress
  wire [8:0] bufBase = isRx ? `MFS_RX_BASE : `MFS_TX_BASE;
  wire [6:0] posIdx = 7'(frameOff + idx[6:0]);
  wire [8:0] curAddr = bufBase | {2'b00, posIdx};
  wire [7:0] curByte = mem[curAddr];
  wire [7:0] flen = {1'b0, mem[bufBase | {2'b00, frameOff}][6:0]}; // [R9]
  wire [7:0] micM = {4'h0, ctrlA.micCode, 1'b0} + 8'h02; // [R18]
  wire [7:0] dataEnd = flen - 8'h02 - (doMac ? micM : 8'h00); // [R19]
  wire [7:0] encStart = {1'b0, isRx ? ctrlB.rxl : ctrlB.txl} + 8'h01; // [R16]
  wire [7:0] authStart = isCcm ? 8'h01 : encStart; // [R22]
  wire [7:0] authLen = dataEnd - authStart + 8'h01;
  wire byteReady = isRx | (idx < txCount); // [R17]
  wire wantMac = doMac & ~macDone & (~isRx | ~doCtr | ctrDone);
  wire wantCtr = doCtr & ~ctrDone;
  wire lastMic = j == micM - 8'h01;
  wire [7:0] micByte = mac[127-8*j -: 8] ^ (isCcm ? aesS[127-8*j -: 8] : 8'h00);
  wire micMatch = micByte == curByte;
  wire linkEdge = lkS2 & ~lkS3;
  wire sendDone = st == S_SEND && linkEdge && idx == flen;
  wire goSa = stb[`MFS_STB_SA];
  wire goTxOn = stb[`MFS_STB_TXON] | stb[`MFS_STB_TXCCA];
  wire goTx = goTxOn | stb[`MFS_STB_TXENC];
  wire goRx = stb[`MFS_STB_RXDEC] && ctrlA.mode != MODE_OFF;
  wire ctrWe = st == S_CTR && j != 8'h10 && idx <= dataEnd && byteReady;
  wire micWe = st == S_MIC && byteReady && (~isRx | lastMic);
  wire engWe = st == S_SAWB | ctrWe | micWe;
  wire [8:0] engAddr = st == S_SAWB ? `MFS_SA_BUF + {1'b0, j} : curAddr;
  wire [7:0] micMark = (micOk & micMatch) ? `MFS_MIC_PASS : `MFS_MIC_FAIL;
  wire [7:0] engData = st == S_SAWB ? aesS[8*j +: 8] :
                       ctrWe ? curByte ^ aesS[127-8*j -: 8] :
                       isRx ? micMark : micByte; // [R21]
  wire [6:0] rxUsed = 7'(rxHead - fstart);
  wire [7:0] rxFirstLen = {1'b0, mem[`MFS_RX_BASE | {2'b00, fstart}][6:0]};
  // Host may read only bytes the engine has already finished
  wire rxGate = busy & isRx & ({1'b0, rxUsed} >= doneOff);
  assign rxDataAvail = (rxHead != rxTail) & ~rxGate; // [R15]
  assign rxThresholdPin = rxDataAvail & ({1'b0, 7'(rxTail - fstart)} > rxFirstLen); // [R15]
  assign txLinkActive = txOn;

  // Held up to the link edge after the last byte, so the far end still takes that byte
  always_ff @(posedge clk)
  begin
    if (srst) txOn <= 1'b0;
    else if (linkEdge) txOn <= st == S_SEND; // [R13]
  end

  always_comb
  begin
    rdWord = '0;
    case (dIdx)
      `MFS_REG_CTRL_A: rdWord[8:0] = ctrlA;
      `MFS_REG_CTRL_B: rdWord[13:0] = ctrlB;
      `MFS_REG_STATUS: rdWord[2:0] = {micPass, st == S_SEND, busy}; // [R23]
      `MFS_REG_RX_POP: rdWord[7:0] = mem[`MFS_RX_BASE | {2'b00, rxHead}];
      `MFS_REG_PREV: rdWord[7:0] = prevData;
      `MFS_REG_TX_PUSH: rdWord[7:0] = txCount;
      default: if (dIdx < `MFS_RAM_TOP) rdWord[7:0] = mem[dIdx];
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dValid <= 1'b0;
      dWrite <= 1'b0;
      rdDone <= 1'b0;
      dIdx <= `MFS_REG_NONE;
      hrdata <= '0;
    end
    else
    begin
      if (hreadyout)
      begin
        dValid <= addrTake;
        dWrite <= hwrite;
        dIdx <= (haddr[31:11] == 21'h0 && hsize == 3'h2) ? haddr[10:2] : `MFS_REG_NONE;
      end
      rdDone <= rdNow;
      if (rdNow) hrdata <= rdWord;
    end
  end

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {lkS1, lkS2, lkS3, rvS1, rvS2} <= 5'h00;
      rdS1 <= 8'h00;
      rdS2 <= 8'h00;
    end
    else
    begin
      {lkS1, lkS2, lkS3} <= {linkClk, lkS1, lkS2};
      {rvS1, rvS2} <= {rxLinkValid, rvS1};
      rdS1 <= rxLinkData;
      rdS2 <= rdS1;
    end
  end
  wire rxPush = linkEdge & rvS2 & (7'(rxTail + 7'h01) != rxHead);

  always_ff @(posedge clk)
  begin
    if (hostRamWe) mem[dIdx] <= hwdata[7:0];
    if (txPush) mem[`MFS_TX_BASE | {1'b0, txCount}] <= hwdata[7:0];
    if (rxPush) mem[`MFS_RX_BASE | {2'b00, rxTail}] <= rdS2;
    if (engWe) mem[engAddr] <= engData;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrlA <= `MFS_CTRL_A_RST;
      ctrlB <= `MFS_CTRL_B_RST;
      prevData <= 8'h00;
      txCount <= 8'h00;
      {rxHead, rxTail, fstart} <= '0;
    end
    else
    begin
      if (wrNow && dIdx == `MFS_REG_CTRL_A) ctrlA <= hwdata[8:0];
      if (wrNow && dIdx == `MFS_REG_CTRL_B) ctrlB <= hwdata[13:0];
      if (hostRamWe) prevData <= mem[dIdx]; // [R8]
      if (sendDone) txCount <= 8'h00;
      else if (txPush) txCount <= txCount + 8'h01;
      if (rxPush) rxTail <= rxTail + 7'h01;
      if (rxPop)
      begin
        rxHead <= rxHead + 7'h01;
        // Frame start stays put until the whole first frame is read out
        if ({1'b0, rxUsed} == rxFirstLen) fstart <= rxHead + 7'h01; // [R14]
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aesRun <= 1'b0;
      aesS <= '0;
      aesK <= '0;
      rcon <= 8'h01;
      rnd <= 4'h0;
    end
    else if (st == S_AESGO)
    begin
      aesS <= aesSrc ^ ramBlk(keyBase);
      aesK <= ramBlk(keyBase);
      rcon <= 8'h01;
      rnd <= 4'h1;
      aesRun <= 1'b1;
    end
    else if (aesRun)
    begin
      aesS <= aesRound(aesS, nextKey(aesK, rcon), rnd == `MFS_AES_LAST);
      aesK <= nextKey(aesK, rcon);
      rcon <= xt(rcon);
      rnd <= rnd + 4'h1;
      if (rnd == `MFS_AES_LAST) aesRun <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= S_IDLE;
      retSt <= S_IDLE;
      {isRx, isCcm, doMac, doCtr, sendAfter, macDone, ctrDone, micDone} <= 8'h00;
      {micOk, micPass} <= 2'b00;
      {idx, j, doneOff} <= '0;
      frameOff <= 7'h00;
      {aesSrc, mac, blk} <= '0;
      keyBase <= `MFS_KEY_A;
      nonceBase <= `MFS_NONCE_TX;
      ctr <= 16'h0000;
      txLinkData <= 8'h00;
    end
    else
    begin
      case (st)
        S_IDLE:
          if (goSa)
          begin
            keyBase <= ctrlA.saKey ? `MFS_KEY_B : `MFS_KEY_A; // [R1] [R2]
            aesSrc <= ramBlk(`MFS_SA_BUF); // [R7]
            retSt <= S_SAWB;
            j <= 8'h00;
            st <= S_AESGO;
          end
          else if (goTx | goRx)
          begin
            isRx <= goRx & ~goTx;
            frameOff <= goTx ? 7'h00 : fstart; // [R14]
            keyBase <= (goTx ? ctrlA.txKey : ctrlA.rxKey) ? `MFS_KEY_B : `MFS_KEY_A;
            nonceBase <= goTx ? `MFS_NONCE_TX : `MFS_NONCE_RX; // [R3]
            sendAfter <= goTx & goTxOn; // [R12] [R13]
            doMac <= ctrlA.mode == MODE_CBC || ctrlA.mode == MODE_CCM; // [R11]
            doCtr <= ctrlA.mode == MODE_CTR || ctrlA.mode == MODE_CCM;
            isCcm <= ctrlA.mode == MODE_CCM;
            {macDone, ctrDone, micDone} <= 3'b000;
            idx <= 8'h00;
            doneOff <= 8'h00;
            if (ctrlA.mode != MODE_OFF) st <= S_START;
            else if (goTxOn) st <= S_SEND;
          end
        S_AESGO: st <= S_AES;
        S_AES: if (!aesRun) st <= retSt;
        S_SAWB:
        begin
          j <= j + 8'h01;
          if (j == 8'h0F) st <= S_IDLE;
        end
        S_START: if (byteReady) st <= S_NEXT; // [R17]
        S_NEXT:
          if (wantMac)
          begin
            idx <= authStart;
            mac <= '0;
            blk <= ctrlA.prefixSel ? {authLen, 120'h0} : '0; // [R20]
            j <= ctrlA.prefixSel ? 8'h01 : 8'h00;
            st <= S_MAC;
          end
          else if (wantCtr)
          begin
            idx <= encStart;
            ctr <= {mem[nonceBase + 9'h001], mem[nonceBase]}; // [R5]
            st <= S_CTRKS;
          end
          else if (doMac && !micDone)
          begin
            idx <= dataEnd + 8'h01;
            j <= 8'h00;
            micOk <= 1'b1;
            aesSrc <= ctrBlk(nonceBase, 16'h0000);
            retSt <= S_MIC;
            st <= isCcm ? S_AESGO : S_MIC;
          end
          else
          begin
            idx <= 8'h00;
            frameOff <= 7'h00;
            st <= sendAfter ? S_SEND : S_IDLE; // [R13]
          end
        S_MAC:
          if (idx > dataEnd)
          begin
            if (j != 8'h00)
            begin
              aesSrc <= mac ^ blk;
              retSt <= S_CBCD;
              st <= S_AESGO;
            end
            else
            begin
              macDone <= 1'b1;
              st <= S_NEXT;
            end
          end
          else if (byteReady)
          begin
            blk <= setByte(blk, j, curByte);
            idx <= idx + 8'h01;
            j <= j + 8'h01;
            if (j == 8'h0F)
            begin
              aesSrc <= mac ^ setByte(blk, j, curByte);
              retSt <= S_CBCD;
              st <= S_AESGO;
            end
          end
        S_CBCD:
        begin
          mac <= aesS;
          blk <= '0;
          j <= 8'h00;
          st <= S_MAC;
        end
        S_CTRKS:
          if (idx > dataEnd)
          begin
            ctrDone <= 1'b1;
            st <= S_NEXT;
          end
          else
          begin
            aesSrc <= ctrBlk(nonceBase, ctr);
            retSt <= S_CTR;
            j <= 8'h00;
            st <= S_AESGO;
          end
        S_CTR:
          if (j == 8'h10 || idx > dataEnd)
          begin
            ctr <= ctr + 16'h0001; // [R5]
            st <= S_CTRKS;
          end
          else if (byteReady)
          begin
            j <= j + 8'h01;
            idx <= idx + 8'h01;
            doneOff <= idx + 8'h01; // [R15]
          end
        S_MIC:
          // A MIC slot not yet pushed would be overwritten by the later push
          if (byteReady) // [R17]
          begin
            micOk <= micOk & (~isRx | micMatch);
            j <= j + 8'h01;
            idx <= idx + 8'h01;
            if (lastMic)
            begin
              micPass <= micOk & (~isRx | micMatch);
              micDone <= 1'b1;
              st <= S_NEXT;
            end
          end
        S_SEND:
          if (linkEdge)
          begin
            txLinkData <= curByte;
            idx <= idx + 8'h01;
            if (idx == flen) st <= S_IDLE;
          end
        default: st <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire [8:0] nb0 = nonceBase;
  property p_busyIgnore;
    (busy && stb != 5'h00) |=> $stable(keyBase) && $stable(isRx) && $stable(sendAfter);
  endproperty
  a_busyIgnore: assert property (p_busyIgnore) else $error("strobe disturbed a busy engine"); // [R23]
  property p_saStart;
    (st == S_IDLE && goSa) |=> st == S_AESGO ##1 st == S_AES ##11 st == S_SAWB;
  endproperty
  a_saStart: assert property (p_saStart) else $error("stand-alone run not 11 cycles"); // [R7]
  property p_aesLen;
    $rose(aesRun) |-> ##9 aesRun ##1 !aesRun;
  endproperty
  a_aesLen: assert property (p_aesLen) else $error("AES did not take ten rounds"); // [R7]
  property p_rxGate;
    (st == S_IDLE && goRx && !goSa && !goTx) |=> !rxDataAvail && !rxThresholdPin;
  endproperty
  a_rxGate: assert property (p_rxGate) else $error("data-available pins not lowered"); // [R15]
  property p_micMark;
    (st == S_MIC && isRx && engWe) |-> lastMic && (engData == 8'h00 || engData == 8'hFF);
  endproperty
  a_micMark: assert property (p_micMark) else $error("receive MIC byte wrongly written"); // [R21]
  property p_txStall;
    (ctrWe && !isRx) |-> idx < txCount;
  endproperty
  a_txStall: assert property (p_txStall) else $error("encrypted an unwritten byte"); // [R17]
  property p_noCtrWb;
    engWe |-> (engAddr != nb0 && engAddr != nb0 + 9'h001);
  endproperty
  a_noCtrWb: assert property (p_noCtrWb) else $error("block counter written to RAM"); // [R5]
  property p_prevData;
    hostRamWe |=> prevData == $past(mem[dIdx]);
  endproperty
  a_prevData: assert property (p_prevData) else $error("old RAM byte not returned"); // [R8]
  property p_keyBase;
    st == S_AES |-> (keyBase == `MFS_KEY_A || keyBase == `MFS_KEY_B);
  endproperty
  a_keyBase: assert property (p_keyBase) else $error("key taken from wrong address"); // [R2]
  property p_encOnly;
    (st == S_IDLE && stb == 5'h02 && ctrlA.mode != MODE_OFF) |=> !sendAfter;
  endproperty
  a_encOnly: assert property (p_encOnly) else $error("encrypt-only would transmit"); // [R12]
  c_sa: cover property (st == S_SAWB && j == 8'h0F);
  c_send: cover property (sendDone);
  c_rxMic: cover property (micWe && isRx);
  c_ctr: cover property (ctrWe && isRx);
endmodule

// ==== mfs_link_peer.sv ====
// Purpose: link-side peer of the frame security engine
// Assumes: the link clock runs only while run is high
// Notes: a released data line shows the inverse of its last byte
`timescale 1ns/1ps
module mfs_link_peer (
  input wire logic run,
  input wire logic [7:0] txLinkData,
  input wire logic txLinkActive,
  output logic linkClk,
  output logic rxLinkValid,
  output logic [7:0] rxLinkData
);
  logic [7:0] seen[$];
  initial
  begin
    linkClk = 1'b0;
    rxLinkValid = 1'b0;
    rxLinkData = 8'h5a;
  end
  // Clock stands still low between frames
  always #80 linkClk = run ? ~linkClk : 1'b0;
  // Falling edge: the byte launched at the rising edge has settled
  always @(negedge linkClk)
    if (txLinkActive === 1'b1)
      seen.push_back(txLinkData);
  task automatic send(input logic [7:0] b);
    @(negedge linkClk);
    rxLinkData = b;
    rxLinkValid = 1'b1;
    @(negedge linkClk);
    rxLinkValid = 1'b0;
    rxLinkData = ~b;
  endtask
endmodule

// ==== test_mfs_engine.sv ====
// Purpose: self-checking bench of the frame security engine
// Assumes: each read expectation is queued at its address phase
// Notes: secured transmit frames are judged by their clear header bytes only; the received frame also by its MIC mark
`timescale 1ns/1ps
`include "mfs_cfg.svh"
module test_mfs_engine
  import mfs_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic rdPend = 1'b0, txSeen = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic hreadyout, hresp, linkClk, rxLinkValid, txLinkActive, rxDataAvail, rxThresholdPin;
  logic [7:0] rxLinkData, txLinkData;
  logic [7:0] frm[$];
  logic [63:0] expQ[$];
  mfs_ctrl_a_type ca;
  int n_fail = 0, n_checks = 0;
  // Zero key on zero block, most significant byte first
  localparam logic [127:0] AES_ZERO = 128'h66e9_4bd4_ef8a_2c3b_884c_fa59_ca34_2b2e;
  always #5 clk = ~clk;
  mfs_engine u_mfs_engine (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .linkClk(linkClk),
    .rxLinkValid(rxLinkValid), .rxLinkData(rxLinkData), .txLinkData(txLinkData),
    .txLinkActive(txLinkActive), .rxDataAvail(rxDataAvail), .rxThresholdPin(rxThresholdPin));
  mfs_link_peer u_mfs_link_peer (.run(run), .txLinkData(txLinkData),
    .txLinkActive(txLinkActive), .linkClk(linkClk), .rxLinkValid(rxLinkValid),
    .rxLinkData(rxLinkData));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail();
    chk(32'h0000_0000, 32'h0000_0001);
    results();
  endtask
  // Read data is judged in the edge that ends the read data phase
  always @(posedge clk)
  begin
    if (rdPend && hreadyout === 1'b1)
    begin
      chk(hrdata & expQ[0][63:32], expQ[0][31:0]);
      void'(expQ.pop_front());
    end
    if (hreadyout === 1'b1)
      rdPend = hsel && htrans[1] && !hwrite;
    if (txLinkActive === 1'b1)
      txSeen <= 1'b1;
  end
  task automatic waitReady();
    int w;
    w = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      w++;
      if (w > 50)
        bail();
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd,
      input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {21'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    if (!wr)
      expQ.push_back({m, e});
    waitReady();
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
  endtask
  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, '0, '0);
  endtask
  task automatic rdm(input logic [8:0] idx, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, idx, '0, m, e);
  endtask
  task automatic rd(input logic [8:0] idx, input logic [31:0] e);
    bus(1'b0, idx, '0, 32'hffff_ffff, e);
  endtask
  task automatic waitIdle();
    int w;
    w = 0;
    do
    begin
      rdm(`MFS_REG_STATUS, '0, '0);
      w++;
      if (w > 500)
        bail();
    end
    while (hrdata[`MFS_ST_BUSY] !== 1'b0);
  endtask
  task automatic mkFrame(input int len);
    frm = {};
    frm.push_back(8'(len));
    repeat (len) frm.push_back(8'($urandom));
  endtask
  task automatic pushFrame();
    foreach (frm[i]) wr(`MFS_REG_TX_PUSH, {24'h0, frm[i]});
  endtask
  task automatic sendOut(input int s, input int n);
    int w;
    u_mfs_link_peer.seen = {};
    txSeen = 1'b0;
    run <= 1'b1;
    wr(`MFS_REG_STROBE, 32'h0000_0001 << s);
    for (w = 0; !(txSeen && txLinkActive === 1'b0); w++)
    begin
      if (w > 4000)
        bail();
      @(posedge clk);
    end
    run <= 1'b0;
    for (w = 0; w < n; w++) chk(u_mfs_link_peer.seen[w], frm[w]);
  endtask
  initial
  begin
    void'($urandom(32'h8cb1_08ad));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(`MFS_REG_CTRL_A, '0);
    rd(`MFS_REG_STATUS, '0);
    rd(`MFS_REG_NONE, '0);
    $display("test reset and map done");
    for (int i = 0; i < 16; i++)
    begin
      wr(9'(`MFS_KEY_A + i), '0);
      wr(9'(`MFS_KEY_B + i), 32'h0000_00a5);
      wr(9'(`MFS_NONCE_TX + i), (i == 0) ? 32'h0000_0001 : '0);
      wr(9'(`MFS_NONCE_RX + i), '0);
      wr(9'(`MFS_SA_BUF + i), '0);
    end
    wr(`MFS_KEY_B, 32'h0000_003c);
    rd(`MFS_REG_PREV, 32'h0000_00a5);
    rd(9'(`MFS_KEY_B + 1), 32'h0000_00a5);
    $display("test key store done");
    ca = '0;
    wr(`MFS_REG_CTRL_A, {23'h0, ca});
    wr(`MFS_REG_STROBE, 32'h0000_0001 << `MFS_STB_SA);
    wr(`MFS_REG_STROBE, 32'h0000_0001 << `MFS_STB_SA);
    rdm(`MFS_REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    waitIdle();
    for (int i = 0; i < 16; i++) rd(9'(`MFS_SA_BUF + i), {24'h0, AES_ZERO[8*i +: 8]});
    $display("test stand-alone done");
    for (int m = 0; m < 3; m++)
    begin
      ca.mode = mfs_mode_type'((m == 0) ? 0 : m + 1);
      ca.micCode = 3'h1;
      wr(`MFS_REG_CTRL_A, {23'h0, ca});
      wr(`MFS_REG_CTRL_B, 32'h0000_0003);
      wr(9'(`MFS_NONCE_TX + 3), 32'(m + 1));
      mkFrame((m == 0) ? 5 : 12);
      if (m != 0)
      begin
        txSeen = 1'b0;
        wr(`MFS_REG_STROBE, 32'h0000_0001 << `MFS_STB_TXENC);
        pushFrame();
        waitIdle();
        chk(txSeen, 1'b0);
        for (int i = 0; i < 4; i++) rd(9'(`MFS_TX_BASE + i), {24'h0, frm[i]});
      end
      else
        pushFrame();
      sendOut((m == 1) ? `MFS_STB_TXCCA : `MFS_STB_TXON, (m == 0) ? 6 : 4);
    end
    rd(`MFS_NONCE_TX, 32'h0000_0001);
    $display("test transmit done");
    mkFrame(10);
    run <= 1'b1;
    foreach (frm[i]) u_mfs_link_peer.send(frm[i]);
    run <= 1'b0;
    for (int i = 0; i < 3; i++) rd(`MFS_REG_RX_POP, {24'h0, frm[i]});
    chk(rxDataAvail, 1'b1);
    chk(rxThresholdPin, 1'b1);
    ca.mode = MODE_CBC;
    ca.prefixSel = 1'b1;
    wr(`MFS_REG_CTRL_A, {23'h0, ca});
    wr(`MFS_REG_STROBE, 32'h0000_0001 << `MFS_STB_RXDEC);
    @(posedge clk);
    chk({rxDataAvail, rxThresholdPin, hresp}, 3'b000);
    waitIdle();
    rd(9'(`MFS_RX_BASE + 7), {24'h0, frm[7]});
    rd(9'(`MFS_RX_BASE + 8), {24'h0, `MFS_MIC_FAIL});
    rdm(`MFS_REG_STATUS, 32'h0000_0004, '0);
    $display("test receive check done");
    results();
  end
endmodule
